// ---- pfm_pkg.sv ----
// pfm_pkg: constants shared by the pin function matrix
// assumes an apb slave with 32-bit aligned registers
package pfm_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NPIN = 18;  // port pins 0..17
  localparam int NFN = 4;  // movable outputs, and inputs
  localparam int NCH = 8;  // pin interrupt channels
  typedef logic [NFN-1:0][7:0] pfm_sel_t;  // one pin number a byte
  typedef logic [NCH-1:0][7:0] pfm_chsel_t;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_FIXED = 8'h00;
  localparam logic [7:0] OFS_OSEL = 8'h04;
  localparam logic [7:0] OFS_ISEL = 8'h08;
  localparam logic [7:0] OFS_DIR = 8'h0C;
  localparam logic [7:0] OFS_OUT = 8'h10;
  localparam logic [7:0] OFS_SET = 8'h14;
  localparam logic [7:0] OFS_CLR = 8'h18;
  localparam logic [7:0] OFS_PIN = 8'h1C;
  localparam logic [7:0] OFS_PULL = 8'h20;
  localparam logic [7:0] OFS_ANA = 8'h24;
  localparam logic [7:0] OFS_CSEL0 = 8'h28;
  localparam logic [7:0] OFS_CSEL1 = 8'h2C;
  localparam logic [7:0] OFS_CMODE = 8'h30;
  localparam logic [7:0] OFS_CFLAG = 8'h34;
  localparam logic [7:0] OFS_CTRL = 8'h38;
  localparam logic [7:0] OFS_STAT = 8'h3C;
  // ----------------------------------------
  // fixed function enable bits
  // ----------------------------------------
  localparam int FX_CMP1 = 0;
  localparam int FX_CMP2 = 1;
  localparam int FX_DDATA = 2;
  localparam int FX_DCLK = 3;
  localparam int FX_RST = 4;
  localparam int FX_XIN = 5;
  localparam int FX_XOUT = 6;
  localparam logic [6:0] FIXED_RST = 7'h1C;  // debug pair and reset on
  // ----------------------------------------
  // pin numbers
  // ----------------------------------------
  localparam int PORT_PIN_ZERO = 0;
  localparam int LEGACY_BOOT_SELECT_PIN = 1;
  localparam int DEBUG_DATA_PIN = 2;
  localparam int DEBUG_CLOCK_PIN = 3;
  localparam int DEEP_WAKE_PIN = 4;
  localparam int RESET_INPUT_PIN = 5;
  localparam int XTAL_IN_PIN = 8;
  localparam int XTAL_OUT_PIN = 9;
  localparam int OPEN_DRAIN_PIN_A = 10;
  localparam int OPEN_DRAIN_PIN_B = 11;
  localparam int BOOT_SELECT_PIN = 12;
  localparam int NTAP = 5;  // pins taken in boundary scan
  localparam int SERIAL0_RECEIVE = 0;  // movable input index
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] SEL_NONE = 8'hFF;
  localparam logic [17:0] PULL_RST = 18'h3F3FF;  // not on open drain
  localparam int CM_LEVEL = 0;  // mode byte: level select
  localparam int CM_RISE = 8;  // rise, or high active
  localparam int CM_FALL = 16;  // fall, or low active
  localparam int CT_WAKEDIS = 0;
  localparam int CT_ISPEXIT = 1;
endpackage : pfm_pkg

// ---- pfm_matrix.sv ----
// pfm_matrix: pin function matrix with apb registers
// assumes pin inputs synchronous to pclk; pads resolve pin_out/pin_oe_n
//
// Functional notes
// R1: reset gives gpio, except debug pair, reset
// R2: fixed pins switch gpio or fixed function
// R3: any movable function onto any port pin
// R4: one output per pin; inputs may share
// R5: routed function disconnects the pin's gpio
// R6: boundary scan takes pins zero to four
// R7: low deep wake pin wakes deep power-down
// R8: boot select low at reset enters programming
// R9: programming mode: pin zero feeds serial receive
// R10: gpio pins reset as inputs with pull-up; open drain pins 10 and 11 reset without one
// R11: analog or oscillator use disables digital
// R12: open drain pins never drive high
// R13: unbonded open drain pins driven low by software
// R14: reset pin inactive in deep power-down
// R15: wake pin disable needs low power oscillator
// R16: eight pin interrupts, level or edges
// R17: boundary scan beats software routing
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module pfm_matrix
(
  // clock and reset
  input logic pclk,
  input logic presetn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // package pins
  input logic [pfm_pkg::NPIN-1:0] pin_in,
  output logic [pfm_pkg::NPIN-1:0] pin_out,
  output logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  output logic [pfm_pkg::NPIN-1:0] pin_pullup,
  output logic [pfm_pkg::NPIN-1:0] pin_dig_en,
  // movable functions
  input logic [pfm_pkg::NFN-1:0] mov_out,
  input logic [pfm_pkg::NFN-1:0] mov_out_en,
  output logic [pfm_pkg::NFN-1:0] mov_in,
  // debug, reset, oscillator
  input logic dbg_dio_out,
  input logic dbg_dio_en,
  output logic dbg_dio_in,
  output logic dbg_clk,
  output logic xtal_en,
  output logic sys_reset_req,
  // boundary scan
  input logic scan_mode,
  input logic tap_tdo,
  output logic tap_tdi,
  output logic tap_tck,
  output logic tap_tms,
  output logic tap_trst_n,
  // power and boot
  input logic deep_pd,
  input logic wake_osc_en,
  output logic wake_req,
  output logic isp_mode,
  // pin interrupts
  output logic [pfm_pkg::NCH-1:0] pint_irq
);
  import pfm_pkg::*;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [6:0] fixed_q;  // fixed function enables
  pfm_sel_t osel_q;  // pin of each movable output
  pfm_sel_t isel_q;  // pin of each movable input
  logic [NPIN-1:0] dir_q;  // port_direction_bits
  logic [NPIN-1:0] gout_q;  // gpio output levels
  logic [NPIN-1:0] pull_q;  // pullup_active
  logic [NPIN-1:0] ana_q;  // analog mode
  pfm_chsel_t csel_q;  // pin of each interrupt channel
  logic [23:0] cmode_q;  // level, rise, fall bytes
  logic [NCH-1:0] cflag_q;  // sticky edge flags
  logic [NCH-1:0] cprev_q;  // previous channel level
  logic wakedis_q;  // wake pin release request
  logic isp_q;  // in_system_programming active
  logic strap_q;  // boot strap already taken
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic rd_ok;
  logic wr;  // apb write takes effect
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // first movable output routed to pin p, lowest index wins
  function automatic logic [2:0] out_owner(input pfm_sel_t s, input int p);
    logic [2:0] r;
    r = 3'h0;
    for (int f = NFN - 1; f >= 0; f--) begin
      if (s[f] == 8'(p)) begin
        r = {1'b1, 2'(f)};
      end
    end
    return r;
  endfunction : out_owner
  // any movable input routed to pin p
  function automatic logic in_used(input pfm_sel_t s, input int p);
    logic r;
    r = 1'b0;
    for (int f = 0; f < NFN; f++) begin
      if (s[f] == 8'(p)) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : in_used
  // ----------------------------------------
  // per pin routing
  // ----------------------------------------
  logic [NPIN-1:0] ana_en;  // digital section off
  logic [NPIN-1:0] pin_dig;  // digital pin level
  logic [NPIN-1:0] drv;  // pad drive wanted
  logic [NPIN-1:0] val;  // level to drive
  logic [NPIN-1:0] fx_ana;  // analog fixed functions
  logic wake_dis_eff;
  assign fx_ana = NPIN'(
      ({17'h0, fixed_q[FX_CMP1]} << PORT_PIN_ZERO)
    | ({17'h0, fixed_q[FX_CMP2]} << LEGACY_BOOT_SELECT_PIN)
    | ({17'h0, fixed_q[FX_XIN]} << XTAL_IN_PIN)
    | ({17'h0, fixed_q[FX_XOUT]} << XTAL_OUT_PIN));
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic [2:0] own;
    logic tap;
    assign own = out_owner(osel_q, p);
    assign tap = scan_mode && (p < NTAP);
    // analog and oscillator pins lose digital; scan keeps its pins
    assign ana_en[p] = ~tap & (ana_q[p] | fx_ana[p]);  // R11
    assign pin_dig[p] = pin_in[p] & ~ana_en[p];  // R11
    assign pin_dig_en[p] = ~ana_en[p];
    assign pin_pullup[p] = pull_q[p] & ~ana_en[p];
    // drive source, highest priority first
    always_comb begin
      drv[p] = 1'b0;
      val[p] = 1'b1;
      if (tap) begin
        // scan owns pin zero as test data out
        drv[p] = (p == PORT_PIN_ZERO);  // R6 R17
        val[p] = tap_tdo;  // R6
      end else if (ana_en[p]) begin
        drv[p] = 1'b0;  // R11
      end else if (own[2]) begin
        // movable output replaces fixed and gpio
        drv[p] = mov_out_en[own[1:0]];  // R3 R4 R5
        val[p] = mov_out[own[1:0]];  // R3
      end else if (in_used(isel_q, p)) begin
        drv[p] = 1'b0;  // R5
      end else if (p == DEBUG_DATA_PIN && fixed_q[FX_DDATA]) begin
        drv[p] = dbg_dio_en;  // R2
        val[p] = dbg_dio_out;  // R2
      end else if ((p == DEBUG_CLOCK_PIN && fixed_q[FX_DCLK]) ||
                   (p == RESET_INPUT_PIN && fixed_q[FX_RST])) begin
        drv[p] = 1'b0;  // R2
      end else begin
        // plain gpio, reset as input
        drv[p] = dir_q[p];  // R1 R10
        val[p] = gout_q[p];
      end
    end
    // open drain pads only ever pull low
    if (p == OPEN_DRAIN_PIN_A || p == OPEN_DRAIN_PIN_B) begin : g_od
      assign pin_out[p] = 1'b0;
      assign pin_oe_n[p] = ~(drv[p] & ~val[p]);  // R12 R13
    end else begin : g_pp
      assign pin_out[p] = val[p];
      assign pin_oe_n[p] = ~drv[p];
    end
  end
  // ----------------------------------------
  // movable inputs and fixed function inputs
  // ----------------------------------------
  // unrouted inputs idle high
  for (genvar f = 0; f < NFN; f++) begin : g_min
    always_comb begin
      if (isp_q && f == SERIAL0_RECEIVE) begin
        mov_in[f] = pin_dig[PORT_PIN_ZERO];  // R9
      end else if (isel_q[f] < 8'(NPIN)) begin
        mov_in[f] = pin_dig[isel_q[f][4:0]];  // R3 R4
      end else begin
        mov_in[f] = 1'b1;
      end
    end
  end
  assign dbg_dio_in = fixed_q[FX_DDATA] & pin_dig[DEBUG_DATA_PIN];
  assign dbg_clk = fixed_q[FX_DCLK] & pin_dig[DEBUG_CLOCK_PIN];
  assign xtal_en = fixed_q[FX_XIN] | fixed_q[FX_XOUT];  // R11
  // reset pad ignored while in deep power-down
  assign sys_reset_req = fixed_q[FX_RST] & ~deep_pd & ~pin_in[RESET_INPUT_PIN];  // R14
  // test access inputs only while scanning
  assign tap_tdi = scan_mode & pin_in[1];  // R6
  assign tap_tck = scan_mode & pin_in[2];  // R6
  assign tap_tms = scan_mode & pin_in[3];  // R6
  assign tap_trst_n = ~scan_mode | pin_in[4];  // R6
  // the wake pin may be freed only with the timer oscillator on
  assign wake_dis_eff = wakedis_q & wake_osc_en;  // R15
  assign wake_req = deep_pd & ~wake_dis_eff & ~pin_in[DEEP_WAKE_PIN];  // R7 R14
  assign isp_mode = isp_q;
  // ----------------------------------------
  // boot strap
  // ----------------------------------------
  // boot select caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= 1'b0;
      isp_q <= 1'b0;
    end else if (!strap_q) begin
      strap_q <= 1'b1;
      isp_q <= ~pin_in[BOOT_SELECT_PIN];  // R8
    end else if (wr && paddr == OFS_CTRL && pwdata[CT_ISPEXIT]) begin
      isp_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // pin interrupts
  // ----------------------------------------
  logic [NCH-1:0] ch_lvl;  // channel pin level
  logic [NCH-1:0] ch_set;  // edge seen this cycle
  logic [NCH-1:0] cflag_clr;  // software clear
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic on;
    assign on = csel_q[c] < 8'(NPIN);
    // source is the pad level, whatever is routed there
    assign ch_lvl[c] = on & pin_dig[csel_q[c][4:0]];  // R16
    assign ch_set[c] = on & ~cmode_q[CM_LEVEL+c] &
      ((cmode_q[CM_RISE+c] & ch_lvl[c] & ~cprev_q[c]) |
       (cmode_q[CM_FALL+c] & ~ch_lvl[c] & cprev_q[c]));  // R16
    // level channels follow the pin, edge channels the flag
    assign pint_irq[c] = cmode_q[CM_LEVEL+c]
      ? on & ((cmode_q[CM_RISE+c] & ch_lvl[c]) |
              (cmode_q[CM_FALL+c] & ~ch_lvl[c]))
      : cflag_q[c];  // R16
  end
  assign cflag_clr = (wr && paddr == OFS_CFLAG) ? pwdata[NCH-1:0] : '0;
  // edge flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cflag_q <= '0;
      cprev_q <= '0;
    end else begin
      cprev_q <= ch_lvl;
      cflag_q <= (cflag_q & ~cflag_clr) | ch_set;  // R16
    end
  end
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait state; write lands on the completing edge
  assign wr = psel & penable & pwrite & pready_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~rd_ok;
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  // read mux; set and clear read as zero
  always_comb begin
    rd_d = '0;
    rd_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_STAT);
    case (paddr)
      OFS_FIXED: rd_d = {25'h0, fixed_q};
      OFS_OSEL: rd_d = osel_q;
      OFS_ISEL: rd_d = isel_q;
      OFS_DIR: rd_d = {14'h0, dir_q};
      OFS_OUT: rd_d = {14'h0, gout_q};
      OFS_PIN: rd_d = {14'h0, pin_dig};
      OFS_PULL: rd_d = {14'h0, pull_q};
      OFS_ANA: rd_d = {14'h0, ana_q};
      OFS_CSEL0: rd_d = csel_q[3:0];
      OFS_CSEL1: rd_d = csel_q[7:4];
      OFS_CMODE: rd_d = {8'h0, cmode_q};
      OFS_CFLAG: rd_d = {24'h0, cflag_q};
      OFS_CTRL: rd_d = {31'h0, wakedis_q};
      OFS_STAT: rd_d = {28'h0, wake_dis_eff, deep_pd, scan_mode, isp_q};
      default: rd_d = '0;
    endcase
  end
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_q <= FIXED_RST;  // R1
      osel_q <= {NFN{SEL_NONE}};
      isel_q <= {NFN{SEL_NONE}};
      pull_q <= PULL_RST;  // R10
      ana_q <= '0;
      csel_q <= {NCH{SEL_NONE}};
      cmode_q <= '0;
      wakedis_q <= 1'b0;
    end else if (wr) begin
      case (paddr)
        OFS_FIXED: fixed_q <= pwdata[6:0];  // R2
        OFS_OSEL: osel_q <= pwdata;  // R3
        OFS_ISEL: isel_q <= pwdata;  // R3
        OFS_PULL: pull_q <= pwdata[NPIN-1:0];
        OFS_ANA: ana_q <= pwdata[NPIN-1:0];  // R11
        OFS_CSEL0: csel_q[3:0] <= pwdata;
        OFS_CSEL1: csel_q[7:4] <= pwdata;
        OFS_CMODE: cmode_q <= pwdata[23:0];
        OFS_CTRL: wakedis_q <= pwdata[CT_WAKEDIS];
        default: ;
      endcase
    end
  end
  // gpio direction and level, with set and clear writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= '0;  // R10
      gout_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFS_DIR: dir_q <= pwdata[NPIN-1:0];
        OFS_OUT: gout_q <= pwdata[NPIN-1:0];
        OFS_SET: gout_q <= gout_q | pwdata[NPIN-1:0];
        OFS_CLR: gout_q <= gout_q & ~pwdata[NPIN-1:0];  // R13
        default: ;
      endcase
    end
  end
endmodule : pfm_matrix

// ---- pfm_board.sv ----
// pfm_board: board circuitry on the package pins
// assumes pfm_matrix pads; the bench drives drv_en/drv_val
`timescale 1ns/1ns
module pfm_board
  import pfm_pkg::*;
(
  // clock and bench drive
  input logic pclk,
  input logic [pfm_pkg::NPIN-1:0] drv_en, drv_val,
  // device pads
  input logic [pfm_pkg::NPIN-1:0] pin_out, pin_oe_n, pin_pullup,
  output logic [pfm_pkg::NPIN-1:0] pin_in
);
  // external pull-ups on the open drain pair
  localparam logic [17:0] EXT_PULLUP = 18'h00C00;
  logic [pfm_pkg::NPIN-1:0] last_q = '0; // last level seen
  // device wins, then bench, then pull-up; a floating pin drifts
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else if (pin_pullup[i] || EXT_PULLUP[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_q[i];
    end
  end
  // remember the level so a floating pin never holds it
  always_ff @(posedge pclk) last_q <= pin_in;
endmodule : pfm_board

// ---- pfm_matrix_chk.sv ----
// pfm_matrix_chk: port assertions for the pin function matrix
// assumes one clock pclk and asynchronous presetn
`timescale 1ns/1ns
module pfm_matrix_chk
  import pfm_pkg::*;
(
  // clock, reset, apb
  input logic pclk, presetn, psel, penable, pready, pslverr,
  input logic [7:0] paddr,
  // pins and movable inputs
  input logic [pfm_pkg::NPIN-1:0] pin_in, pin_out, pin_oe_n,
  input logic [pfm_pkg::NFN-1:0] mov_in,
  // scan, power, boot
  input logic scan_mode, tap_tdo, tap_tdi, tap_tck, tap_trst_n,
  input logic deep_pd, wake_osc_en, wake_req, sys_reset_req, isp_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // apb
  // ----
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  a_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_refuse_addr: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h3C))
    else $error("pslverr wrong for address");
  // ----
  // pins
  // ----
  a_od_low: assert property ((pin_out[11:10] & ~pin_oe_n[11:10]) == 2'b00)
    else $error("open drain pin driven high");
  a_scan_in: assert property (scan_mode |-> tap_tdi == pin_in[1] && tap_tck == pin_in[2] && tap_trst_n == pin_in[4])
    else $error("scan inputs not from pins");
  a_scan_out: assert property (scan_mode |-> !pin_oe_n[0] && pin_out[0] == tap_tdo)
    else $error("scan output not on pin zero");
  a_scan_idle: assert property (!scan_mode |-> !tap_tck && tap_trst_n)
    else $error("scan signals active outside scan");
  // ----
  // power and boot
  // ----
  a_wake_low: assert property (deep_pd && !pin_in[DEEP_WAKE_PIN] && !wake_osc_en |-> wake_req)
    else $error("no wake on low wake pin");
  a_wake_awake: assert property (!deep_pd |-> !wake_req)
    else $error("wake outside deep power-down");
  a_rst_deep: assert property (deep_pd |-> !sys_reset_req)
    else $error("reset pin active in deep power-down");
  a_boot_strap: assert property (presetn && !$past(presetn) |=> isp_mode == !$past(pin_in[BOOT_SELECT_PIN]))
    else $error("boot strap not sampled");
  a_isp_rx: assert property (isp_mode |-> mov_in[SERIAL0_RECEIVE] == pin_in[PORT_PIN_ZERO])
    else $error("serial receive not from pin zero");
endmodule : pfm_matrix_chk

bind pfm_matrix pfm_matrix_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .paddr,
  .pin_in, .pin_out, .pin_oe_n, .mov_in, .scan_mode, .tap_tdo, .tap_tdi, .tap_tck, .tap_trst_n,
  .deep_pd, .wake_osc_en, .wake_req, .sys_reset_req, .isp_mode);

// ---- tb_top.sv ----
// tb_top: self-checking bench for the pin function matrix
// assumes pfm_matrix, pfm_board and the bound checker
`timescale 1ns/1ns
module tb_top;
  import pfm_pkg::*;
  // ----
  // signals and register model
  // ----
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, lv;
  logic [7:0] paddr = 0, ef;
  logic [31:0] pwdata = 0, prdata, r, v;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_dig_en, drv_en = 0, drv_val = 0;
  logic [NFN-1:0] mov_out = 0, mov_out_en = 0, mov_in;
  logic dbg_dio_out = 0, dbg_dio_en = 0, scan_mode = 0, tap_tdo = 0, deep_pd = 0, wake_osc_en = 0;
  logic dbg_dio_in, dbg_clk, xtal_en, sys_reset_req, tap_tdi, tap_tck, tap_tms, tap_trst_n, wake_req, isp_mode;
  logic [NCH-1:0] pint_irq;
  logic [31:0] rm [16];
  int num_errors = 0, num_checks = 0, seed = 32'hD936, p;
  pfm_matrix DUT (.*);
  pfm_board u_board (.*);
  always #20 pclk = ~pclk;
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one transfer; refused above 0x3C or unaligned
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    // wait for the answer; only the watchdog ends a hung transfer
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    chk(e, a > 8'h3C || a[1:0] != 2'b00);
  endtask : apb
  function automatic logic [31:0] msk(input logic [3:0] i);
    case (i)
      0: return 32'h7F;
      3, 4, 8, 9: return 32'h3FFFF;
      12: return 32'hFFFFFF;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction : msk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (a == OFS_SET) rm[4] |= d & 32'h3FFFF;
    else if (a == OFS_CLR) rm[4] &= ~d;
    else if (a <= 8'h3C && a[1:0] == 2'b00) rm[a[5:2]] = d & msk(a[5:2]);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(r, x);
  endtask : rd
  // reset with the boot strap held at boot
  task automatic do_reset(input logic boot);
    presetn <= 0;
    drv_en[BOOT_SELECT_PIN] <= 1;
    drv_val[BOOT_SELECT_PIN] <= boot;
    tick(6);
    presetn <= 1;
    foreach (rm[i]) rm[i] = (i inside {1, 2, 10, 11}) ? 32'hFFFFFFFF : 32'h0;
    rm[0] = FIXED_RST;
    rm[8] = PULL_RST;
    tick(2);
    chk(isp_mode, !boot);
    drv_en[BOOT_SELECT_PIN] <= 0;
  endtask : do_reset
  // pin 17 feeds channels 0 to 4; edge flags stay until cleared
  task automatic edge17(input logic b);
    if (b && !lv) ef |= 8'h0A;
    if (!b && lv) ef |= 8'h0C;
    lv = b;
    drv_val[17] <= b;
    tick(3);
    chk(pint_irq, ef | {3'b0, !b, 3'b0, b});
  endtask : edge17
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ----
  // main sequence
  // ----
  initial begin
    do_reset(1);
    chk(pin_oe_n, {NPIN{1'b1}});
    chk({pin_pullup, mov_in}, {PULL_RST, 4'hF});
    for (int i = 0; i < 13; i++) if (!(i inside {[5:7]})) rd(8'(i * 4), rm[i]);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h42, 32'h0);
    rd(OFS_FIXED, rm[0]);
    for (int k = 0; k < 24; k++) begin
      v = $random(seed);
      p = {$random(seed)} % 13;
      if (p inside {[5:7]}) p += 4;
      wr(8'(p * 4), v);
      rd(8'(p * 4), rm[p]);
    end
    // programming boot, debug and reset pins, deep power-down
    do_reset(0);
    rd(OFS_STAT, 32'h1);
    drv_en[5:0] <= 6'h39;
    drv_val[5:0] <= 6'h08;
    dbg_dio_en <= 1;
    dbg_dio_out <= 1;
    tick(2);
    chk(mov_in[0], 1'b0);
    chk({pin_oe_n[2], pin_out[2], dbg_dio_in, dbg_clk, sys_reset_req, wake_req}, 6'b011110);
    deep_pd <= 1;
    tick(1);
    chk({sys_reset_req, wake_req}, 2'b01);
    wr(OFS_CTRL, 32'h1);
    chk(wake_req, 1'b1);
    wake_osc_en <= 1;
    tick(1);
    chk(wake_req, 1'b0);
    rd(OFS_STAT, 32'hD);
    deep_pd <= 0;
    wake_osc_en <= 0;
    wr(OFS_CTRL, 32'h2);
    chk({isp_mode, mov_in[0]}, 2'b01);
    // fixed functions and analog disconnect
    wr(OFS_FIXED, 32'h0);
    chk({pin_oe_n[2], dbg_dio_in, dbg_clk, sys_reset_req}, 4'b1000);
    wr(OFS_FIXED, 32'h60);
    wr(OFS_ANA, 32'h1);
    chk({xtal_en, pin_dig_en[9:8], pin_dig_en[0]}, 4'b1000);
    wr(OFS_ANA, 32'h0);
    wr(OFS_FIXED, 32'h0);
    // gpio and the unbonded open drain pair
    wr(OFS_DIR, 32'h00C40);
    wr(OFS_OUT, v);
    wr(OFS_CLR, 32'h00C00);
    chk({pin_oe_n[11:10], pin_out[11:10], pin_oe_n[6], pin_out[6]}, {5'b0, rm[4][6]});
    wr(OFS_SET, 32'h00C00);
    chk({pin_out[11:10], pin_in[11:10]}, 4'b0011);
    // movable outputs over gpio, shared input
    wr(OFS_DIR, 32'h3E000);
    wr(OFS_OUT, 32'h3E000);
    wr(OFS_OSEL, 32'h100F0E0D);
    wr(OFS_ISEL, 32'h07070707);
    mov_out_en <= 4'hF;
    mov_out <= {v[3:1], 1'b0};
    drv_en[7] <= 1;
    drv_val[7] <= v[4];
    tick(1);
    chk({pin_oe_n[16:13], pin_out[16:13]}, {4'h0, v[3:1], 1'b0});
    chk(mov_in, {4{v[4]}});
    // boundary scan over a routed output
    wr(OFS_OSEL, 32'h100F0E00);
    scan_mode <= 1;
    tap_tdo <= v[5];
    drv_en[4:1] <= 4'hF;
    drv_val[4:1] <= v[9:6];
    tick(1);
    chk({pin_out[0], tap_trst_n, tap_tms, tap_tck, tap_tdi}, {v[5], v[9:6]});
    rd(OFS_STAT, 32'h2);
    scan_mode <= 0;
    tick(1);
    chk({pin_oe_n[0], pin_out[0]}, {1'b0, mov_out[0]});
    // pin interrupts: level high and low, rise, fall, both
    drv_en[17] <= 1;
    drv_val[17] <= 0;
    lv = 0;
    // release pin 17 from its gpio output so the board sets its level
    wr(OFS_DIR, 32'h0);
    wr(OFS_CSEL0, 32'h11111111);
    wr(OFS_CSEL1, 32'hFFFFFF11);
    wr(OFS_CMODE, 32'h001C0B11);
    wr(OFS_CFLAG, 32'hFF);
    ef = 0;
    edge17(0);
    edge17(1);
    edge17(0);
    wr(OFS_CFLAG, 32'h2);
    ef[1] = 0;
    edge17(0);
    close_out();
  end
  // watchdog against a hung handshake
  initial begin
    tick(20000);
    num_errors++;
    close_out();
  end
endmodule : tb_top
